// ==== rtl/cas_defines.vh ====
// constants for the core architectural state and address map
`ifndef CAS_DEFINES_VH
`define CAS_DEFINES_VH
// =============================================
// address map
`define CAS_VEC_LO          16'h0000
`define CAS_VEC_HI_MASK     16'h001f
`define CAS_VEC_HI_FLASH    16'h0023
`define CAS_TCALL_LO        16'h0040
`define CAS_TCALL_HI        16'h007f
`define CAS_RAM_LO          16'hfb00
`define CAS_RAM_HI          16'hfeff
`define CAS_RAM2_LO         16'hf300
`define CAS_RAM2_HI         16'hf6ff
`define CAS_DRAM_LO         16'hfa00
`define CAS_DRAM_HI         16'hfa4f
`define CAS_PERI_LO         16'hff00
`define CAS_RESET_VEC       16'h0000
// =============================================
// state byte
`define CAS_PSB_RESET       8'h02
`define CAS_PSB_GATE        7
`define CAS_PSB_NULL        6
`define CAS_PSB_NIB         4
`define CAS_PSB_CARRY       0
// =============================================
// region codes
`define CAS_RG_VEC          3'h0
`define CAS_RG_TCALL        3'h1
`define CAS_RG_PROG         3'h2
`define CAS_RG_RAM          3'h3
`define CAS_RG_DRAM         3'h4
`define CAS_RG_PERI         3'h5
`define CAS_RG_NONE         3'h6
// =============================================
// core operation codes
`define CAS_OP_NONE         4'h0
`define CAS_OP_JUMP         4'h1
`define CAS_OP_ADD          4'h2
`define CAS_OP_SUB          4'h3
`define CAS_OP_ROT          4'h4
`define CAS_OP_BITLD        4'h5
`define CAS_OP_MASK_ALL     4'h6
`define CAS_OP_UNMASK       4'h7
`define CAS_OP_PUSH_PSB     4'h8
`define CAS_OP_POP_PSB      4'h9
`define CAS_OP_IRQ_ACK      4'ha
`define CAS_OP_IRQ_RET      4'hb
`define CAS_OP_LOAD_SP      4'hc
`define CAS_OP_WREG         4'hd
`define CAS_OP_WPAIR        4'he
`define CAS_OP_ADV          4'hf
`endif

// ==== rtl/cas_addr_decode.v ====
// address map decoder for the unified 64 KB space
`timescale 1ns/1ps
`include "cas_defines.vh"
module cas_addr_decode #(
   parameter FLASH_VARIANT = 1
) (
   input  wire [15:0] addr,
   input  wire        sdir_en,
   input  wire [7:0]  sdir_off,
   output reg  [15:0] eff_addr,
   output reg  [2:0]  region
);
   // ==========================================
   // short direct: operand 20h..ffh gives bit8=0, 00h..1fh gives bit8=1
   always @* begin
      if (sdir_en)
         eff_addr = {7'h7f, (sdir_off < 8'h20), sdir_off};
      else
         eff_addr = addr;
   end

   always @* begin
      if (eff_addr >= `CAS_PERI_LO)
         region = `CAS_RG_PERI;
      else if (eff_addr >= `CAS_RAM_LO && eff_addr <= `CAS_RAM_HI)
         region = `CAS_RG_RAM;
      else if (FLASH_VARIANT != 0 && eff_addr >= `CAS_RAM2_LO &&
               eff_addr <= `CAS_RAM2_HI)
         region = `CAS_RG_RAM;
      else if (eff_addr >= `CAS_DRAM_LO && eff_addr <= `CAS_DRAM_HI)
         region = `CAS_RG_DRAM;
      else if (eff_addr <= (FLASH_VARIANT != 0 ? `CAS_VEC_HI_FLASH
                                               : `CAS_VEC_HI_MASK))
         region = `CAS_RG_VEC;
      else if (eff_addr >= `CAS_TCALL_LO && eff_addr <= `CAS_TCALL_HI)
         region = `CAS_RG_TCALL;
      else if (eff_addr < `CAS_DRAM_LO)
         region = `CAS_RG_PROG;
      else
         region = `CAS_RG_NONE;
   end
endmodule // cas_addr_decode

// ==== rtl/cas_flag_unit.v ====
// flag computation for add, subtract, rotate and bit load
`timescale 1ns/1ps
`include "cas_defines.vh"
module cas_flag_unit (
   input  wire [3:0] op,
   input  wire [7:0] opa,
   input  wire [7:0] opb,
   input  wire       cy_in,
   input  wire       bit_in,
   output reg  [7:0] result,
   output reg        null_f,
   output reg        nib_f,
   output reg        cy_f
);
   reg [8:0] wide;
   reg [4:0] low;
   always @* begin
      wide   = 9'h000;
      low    = 5'h00;
      result = opa;
      nib_f  = 1'b0;
      cy_f   = cy_in;
      case (op)
         `CAS_OP_ADD: begin
            wide  = {1'b0, opa} + {1'b0, opb};
            low   = {1'b0, opa[3:0]} + {1'b0, opb[3:0]};
            result = wide[7:0];
            nib_f = low[4];
            cy_f  = wide[8];
         end
         `CAS_OP_SUB: begin
            wide  = {1'b0, opa} - {1'b0, opb};
            low   = {1'b0, opa[3:0]} - {1'b0, opb[3:0]};
            result = wide[7:0];
            nib_f = low[4];
            cy_f  = wide[8];
         end
         `CAS_OP_ROT: begin
            result = {opa[6:0], opa[7]};
            cy_f   = opa[7];
         end
         `CAS_OP_BITLD: begin
            cy_f = bit_in;
         end
         default: begin
            result = opa;
         end
      endcase
      null_f = (result == 8'h00);
   end
endmodule // cas_flag_unit

// ==== rtl/cas_core_state.v ====
// architectural state of the core: pointers, state byte, working registers
//
// Behaviour
// - 16-bit addresses over one 64 KB space
// - vector area ends 001fh or 0023h
// - vector low byte even, high byte odd
// - table-call entries at 0040h to 007fh
// - internal RAM decode, second bank on flash
// - display RAM decodes at fa00h to fa4fh
// - ff00h to ffffh routed to peripheral space
// - 16-bit pointer advances or loads on branch
// - reset loads pointer from vector 0000h/0001h
// - state byte pushed and popped with stack
// - reset sets state byte to 02h
// - gate 0 refuses maskable, 1 uses masks
// - gate cleared by mask-all, ack; set unmask
// - result-null set when result is zero
// - nibble carry from carry/borrow at bit 3
// - main carry: overflow, rotate out, bit accumulator
// - 16-bit stack pointer, saves to internal RAM only
// - pre-decrement on save, post-increment on restore
// - stack pointer undefined after reset
// - eight 8-bit registers, four 16-bit pairs
// - peripheral 16-bit access needs even address
// - short direct operand below 20h sets address bit 8
`timescale 1ns/1ps
`include "cas_defines.vh"
module cas_core_state #(
   parameter FLASH_VARIANT = 1,
   parameter NUM_IRQ       = 18
) (
   input  wire               clk,
   input  wire               rst_n,
   input  wire [3:0]         op,
   input  wire [2:0]         op_len,
   input  wire [15:0]        op_addr,
   input  wire [2:0]         op_reg,
   input  wire [1:0]         op_pair,
   input  wire [15:0]        op_data,
   input  wire               op_bit,
   input  wire               sdir_en,
   input  wire               acc_wide,
   input  wire               acc_wr,
   input  wire               acc_req,
   input  wire [7:0]         mem_rdata,
   input  wire [NUM_IRQ-1:0] irq_req,
   input  wire [NUM_IRQ-1:0] irq_mask,
   input  wire               nmi_req,
   output reg  [15:0]        mem_addr_q,
   output reg                mem_rd_q,
   output reg                mem_wr_q,
   output reg  [7:0]         mem_wdata_q,
   output reg  [2:0]         region_q,
   output reg                peri_sel_q,
   output reg                peri_err_q,
   output reg  [15:0]        ip_q,
   output reg  [7:0]         psb_q,
   output reg  [15:0]        sp_q,
   output reg                irq_accept_q,
   output reg                boot_done_q,
   output reg  [63:0]        regs_q
);
   // ==========================================
   // sequencer states
   localparam [4:0] ST_VLO  = 5'b00001;
   localparam [4:0] ST_VHI  = 5'b00010;
   localparam [4:0] ST_RUN  = 5'b00100;
   localparam [4:0] ST_POP  = 5'b01000;
   localparam [4:0] ST_POPW = 5'b10000;

   reg  [4:0]  state_q;
   reg  [4:0]  state_d;
   reg  [7:0]  vec_lo_q;
   reg  [15:0] sp_d;
   reg  [7:0]  psb_d;
   reg  [15:0] ip_d;
   reg  [15:0] addr_d;
   reg         rd_d;
   reg         wr_d;
   reg  [7:0]  wdata_d;
   reg  [63:0] regs_d;

   wire [15:0] eff_addr;
   wire [2:0]  region;
   wire [7:0]  fu_result;
   wire        fu_null;
   wire        fu_nib;
   wire        fu_cy;

   // ==========================================
   // helpers
   function [7:0] reg_rd;
      input [63:0] r;
      input [2:0]  idx;
      begin
         reg_rd = r[idx*8 +: 8];
      end
   endfunction

   function in_span;
      input [15:0] a;
      input [15:0] lo;
      input [15:0] hi;
      begin
         in_span = (a >= lo) && (a <= hi);
      end
   endfunction

   // judged on the byte the save would land on, one below the pointer
   function in_ram;
      input [15:0] a;
      begin
         in_ram = in_span(a - 16'h0001, `CAS_RAM_LO, `CAS_RAM_HI) ||
                  (FLASH_VARIANT != 0 &&
                   in_span(a - 16'h0001, `CAS_RAM2_LO, `CAS_RAM2_HI));
      end
   endfunction

   function [15:0] stk_move;
      input [15:0] p;
      input        up;
      begin
         stk_move = up ? p + 16'h0001 : p - 16'h0001;
      end
   endfunction

   function [63:0] reg_wr;
      input [63:0] r;
      input [2:0]  idx;
      input [7:0]  val;
      begin
         reg_wr             = r;
         reg_wr[idx*8 +: 8] = val;
      end
   endfunction

   cas_addr_decode #(
      .FLASH_VARIANT (FLASH_VARIANT)
   ) u_dec (
      .addr     (op_addr),
      .sdir_en  (sdir_en),
      .sdir_off (op_addr[7:0]),
      .eff_addr (eff_addr),
      .region   (region)
   );

   cas_flag_unit u_flags (
      .op     (op),
      .opa    (reg_rd(regs_q, op_reg)),
      .opb    (op_data[7:0]),
      .cy_in  (psb_q[`CAS_PSB_CARRY]),
      .bit_in (op_bit),
      .result (fu_result),
      .null_f (fu_null),
      .nib_f  (fu_nib),
      .cy_f   (fu_cy)
   );

   // maskable needs gate and a clear mask; nmi always passes
   wire irq_any = nmi_req ||
                  (psb_q[`CAS_PSB_GATE] && |(irq_req & ~irq_mask));

   // peripheral window hit, shared by select and error flags
   wire peri_hit = (region == `CAS_RG_PERI);

   // ==========================================
   // next state
   always @* begin
      state_d = state_q;
      sp_d    = sp_q;
      psb_d   = psb_q;
      ip_d    = ip_q;
      addr_d  = mem_addr_q;
      rd_d    = 1'b0;
      wr_d    = 1'b0;
      wdata_d = mem_wdata_q;
      regs_d  = regs_q;
      case (state_q)
         ST_VLO: begin
            addr_d  = `CAS_RESET_VEC + 16'h0001;
            rd_d    = 1'b1;
            state_d = ST_VHI;
         end
         ST_VHI: begin
            ip_d    = {mem_rdata, vec_lo_q};
            state_d = ST_RUN;
         end
         ST_POP: begin
            // byte is only valid while the read strobe stands
            psb_d   = mem_rdata;
            sp_d    = stk_move(sp_q, 1'b1);
            state_d = ST_POPW;
         end
         ST_POPW: begin
            state_d = ST_RUN;
         end
         ST_RUN: begin
            case (op)
               `CAS_OP_ADV:
                  ip_d = ip_q + {13'h0000, op_len};
               `CAS_OP_JUMP:
                  ip_d = op_data;
               `CAS_OP_ADD, `CAS_OP_SUB, `CAS_OP_ROT: begin
                  regs_d = reg_wr(regs_q, op_reg, fu_result);
                  psb_d[`CAS_PSB_NULL]  = fu_null;
                  psb_d[`CAS_PSB_NIB]   = fu_nib;
                  psb_d[`CAS_PSB_CARRY] = fu_cy;
               end
               `CAS_OP_BITLD:
                  psb_d[`CAS_PSB_CARRY] = fu_cy;
               `CAS_OP_MASK_ALL:
                  psb_d[`CAS_PSB_GATE] = 1'b0;
               `CAS_OP_UNMASK:
                  psb_d[`CAS_PSB_GATE] = 1'b1;
               `CAS_OP_PUSH_PSB, `CAS_OP_IRQ_ACK: begin
                  // pre-decrement, then save; refuse outside internal RAM
                  if (in_ram(sp_q)) begin
                     sp_d    = stk_move(sp_q, 1'b0);
                     addr_d  = stk_move(sp_q, 1'b0);
                     wdata_d = psb_q;
                     wr_d    = 1'b1;
                  end
                  // the gate closes even when the save is refused
                  if (op == `CAS_OP_IRQ_ACK)
                     psb_d[`CAS_PSB_GATE] = 1'b0;
               end
               `CAS_OP_POP_PSB, `CAS_OP_IRQ_RET: begin
                  addr_d  = sp_q;
                  rd_d    = 1'b1;
                  state_d = ST_POP;
               end
               `CAS_OP_LOAD_SP:
                  sp_d = op_data;
               `CAS_OP_WREG:
                  regs_d = reg_wr(regs_q, op_reg, op_data[7:0]);
               `CAS_OP_WPAIR:
                  regs_d[op_pair*16 +: 16] = op_data;
               default: begin
                  if (acc_req) begin
                     addr_d = eff_addr;
                     rd_d   = ~acc_wr;
                     wr_d   = acc_wr;
                     wdata_d = op_data[7:0];
                  end
               end
            endcase
         end
         default: state_d = ST_VLO;
      endcase
   end

   // ==========================================
   // registers
   always @(posedge clk) begin
      if (!rst_n) begin
         state_q      <= ST_VLO;
         mem_addr_q   <= `CAS_RESET_VEC;
         mem_rd_q     <= 1'b1;
         mem_wr_q     <= 1'b0;
         mem_wdata_q  <= 8'h00;
         region_q     <= `CAS_RG_VEC;
         peri_sel_q   <= 1'b0;
         peri_err_q   <= 1'b0;
         ip_q         <= 16'h0000;
         psb_q        <= `CAS_PSB_RESET;
         irq_accept_q <= 1'b0;
         boot_done_q  <= 1'b0;
         vec_lo_q     <= 8'h00;
         regs_q       <= 64'h0;
      end else begin
         state_q      <= state_d;
         mem_addr_q   <= addr_d;
         mem_rd_q     <= rd_d;
         mem_wr_q     <= wr_d;
         mem_wdata_q  <= wdata_d;
         ip_q         <= ip_d;
         psb_q        <= psb_d;
         regs_q       <= regs_d;
         boot_done_q  <= (state_d == ST_RUN);
         irq_accept_q <= irq_any && state_q == ST_RUN;
         if (state_q == ST_VLO)
            vec_lo_q <= mem_rdata;
         if (state_q == ST_RUN && acc_req && op == `CAS_OP_NONE) begin
            region_q   <= region;
            peri_sel_q <= peri_hit;
            // wide peripheral access on an odd address is flagged
            peri_err_q <= peri_hit &&
                          acc_wide && eff_addr[0];
         end else begin
            peri_sel_q <= 1'b0;
            peri_err_q <= 1'b0;
         end
      end
   end

   // no reset on purpose: contents stay undefined until software loads it
   always @(posedge clk) begin
      sp_q <= sp_d;
   end
endmodule // cas_core_state

// ==== bench/cas_props.sv ====
// assertion checker for the core state block
`timescale 1ns/1ps
`include "cas_defines.vh"
module cas_props #(
   parameter NUM_IRQ = 18
) (
   input wire               clk,
   input wire               rst_n,
   input wire [3:0]         op,
   input wire [2:0]         op_len,
   input wire [15:0]        op_data,
   input wire [7:0]         mem_rdata,
   input wire [NUM_IRQ-1:0] irq_req,
   input wire [NUM_IRQ-1:0] irq_mask,
   input wire               nmi_req,
   input wire [15:0]        mem_addr_q,
   input wire               mem_rd_q,
   input wire               mem_wr_q,
   input wire [7:0]         mem_wdata_q,
   input wire [2:0]         region_q,
   input wire               peri_sel_q,
   input wire               peri_err_q,
   input wire [15:0]        ip_q,
   input wire [7:0]         psb_q,
   input wire [15:0]        sp_q,
   input wire               irq_accept_q,
   input wire               boot_done_q
);
   // =============================================
   // properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_RESET_PSB: assert property ($rose(rst_n) |-> psb_q == 8'h02)
      else $error("state byte not 02h after reset");
   AST_BOOT_ADDR: assert property ($rose(rst_n) |-> mem_rd_q
      && mem_addr_q == 16'h0000 ##1 mem_rd_q && mem_addr_q == 16'h0001)
      else $error("reset vector not read from 0000h then 0001h");
   AST_BOOT_IP: assert property ($rose(rst_n) ##2 1'b1 |->
      boot_done_q && ip_q == {$past(mem_rdata), $past(mem_rdata, 2)})
      else $error("pointer not loaded from reset vector");
   AST_PUSH: assert property (boot_done_q && op == `CAS_OP_PUSH_PSB
      && sp_q > 16'hfb00 && sp_q <= 16'hff00 |=> mem_wr_q
      && sp_q == $past(sp_q) - 16'h1 && mem_addr_q == sp_q
      && mem_wdata_q == $past(psb_q))
      else $error("push did not pre-decrement and store state byte");
   AST_POP: assert property (boot_done_q && op == `CAS_OP_POP_PSB
      |=> mem_rd_q && mem_addr_q == $past(sp_q) ##1
      psb_q == $past(mem_rdata) && sp_q == $past(sp_q) + 16'h1)
      else $error("pop did not restore then post-increment");
   AST_GATE: assert property (boot_done_q && (op == `CAS_OP_MASK_ALL
      || op == `CAS_OP_UNMASK) |=> psb_q[7] == ($past(op) == `CAS_OP_UNMASK))
      else $error("interrupt gate bit wrong after mask or unmask");
   AST_IRQ: assert property (irq_accept_q |-> $past(nmi_req)
      || $past(psb_q[7]) && |($past(irq_req) & ~$past(irq_mask)))
      else $error("interrupt accepted while gated or masked");
   AST_PERI: assert property (peri_sel_q |-> mem_addr_q[15:8] == 8'hff
      && region_q == `CAS_RG_PERI)
      else $error("peripheral select outside ff00h to ffffh");
   AST_PERI_ERR: assert property (peri_err_q |-> peri_sel_q
      && mem_addr_q[0])
      else $error("wide access error without odd peripheral address");
   AST_JUMP: assert property (boot_done_q && op == `CAS_OP_JUMP
      |=> ip_q == $past(op_data))
      else $error("branch did not load pointer");
   AST_ADV: assert property (boot_done_q && op == `CAS_OP_ADV
      |=> ip_q == $past(ip_q) + $past(op_len))
      else $error("pointer did not advance by length");
   cover property (op == `CAS_OP_PUSH_PSB ##1 mem_wr_q);
   cover property (peri_err_q);
   cover property (irq_accept_q && nmi_req);
   cover property (op == `CAS_OP_IRQ_ACK ##1 mem_wr_q);
endmodule // cas_props

bind cas_core_state cas_props #(.NUM_IRQ(NUM_IRQ)) cas_props_i (
   .clk, .rst_n, .op, .op_len, .op_data, .mem_rdata, .irq_req,
   .irq_mask, .nmi_req, .mem_addr_q, .mem_rd_q, .mem_wr_q,
   .mem_wdata_q, .region_q, .peri_sel_q, .peri_err_q, .ip_q,
   .psb_q, .sp_q, .irq_accept_q, .boot_done_q
);

// ==== bench/cas_mem_model.sv ====
// byte memory standing in for program, data and register space
`timescale 1ns/1ps
module cas_mem_model (
   input  wire        clk,
   input  wire [15:0] addr,
   input  wire        rd,
   input  wire        wr,
   input  wire [7:0]  wdata,
   output wire [7:0]  rdata
);
   // =============================================
   // storage
   reg [7:0] mem [0:65535];
   reg [7:0] last_q = 8'h00;
   initial begin
      mem[16'h0000] = 8'h34;
      mem[16'h0001] = 8'h12;
   end
   // idle bus shows the inverse so a stale byte never passes
   assign rdata = rd ? mem[addr] : ~last_q;
   always @(posedge clk) begin
      if (rd)
         last_q <= mem[addr];
      if (wr)
         mem[addr] <= wdata;
   end
endmodule // cas_mem_model

// ==== bench/cas_core_state_tb_top.sv ====
// self-checking bench for the core state block
`timescale 1ns/1ps
`include "cas_defines.vh"
module cas_core_state_tb_top;
   // =============================================
   // stimulus and wiring
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  op = 4'h0;
   logic [2:0]  op_len = 3'h0, op_reg = 3'h0;
   logic [1:0]  op_pair = 2'h0;
   logic [15:0] op_addr = 16'h0000, op_data = 16'h0000;
   logic        op_bit = 1'b0, sdir_en = 1'b0, acc_wide = 1'b0;
   logic        acc_wr = 1'b0, acc_req = 1'b0, nmi_req = 1'b0;
   logic [17:0] irq_req = 18'h0, irq_mask = 18'h0;
   wire  [7:0]  mem_rdata, mem_wdata_q, psb_q;
   wire  [15:0] mem_addr_q, ip_q, sp_q;
   wire  [63:0] regs_q;
   wire  [2:0]  region_q;
   wire         mem_rd_q, mem_wr_q, peri_sel_q, peri_err_q;
   wire         irq_accept_q, boot_done_q;
   int          error_cnt = 0, n_compared = 0, cyc = 0;
   always #2.5 clk = ~clk;
   cas_core_state cas_core_state_i (
      .clk, .rst_n, .op, .op_len, .op_addr, .op_reg, .op_pair, .op_data,
      .op_bit, .sdir_en, .acc_wide, .acc_wr, .acc_req, .mem_rdata,
      .irq_req, .irq_mask, .nmi_req, .mem_addr_q, .mem_rd_q, .mem_wr_q,
      .mem_wdata_q, .region_q, .peri_sel_q, .peri_err_q, .ip_q, .psb_q,
      .sp_q, .irq_accept_q, .boot_done_q, .regs_q
   );
   cas_mem_model cas_mem_model_i (
      .clk, .addr(mem_addr_q), .rd(mem_rd_q), .wr(mem_wr_q),
      .wdata(mem_wdata_q), .rdata(mem_rdata)
   );
   // =============================================
   // shared tasks
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic tally_and_finish;
      if (error_cnt == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // r feeds length, register, pair and bit; x is sdir, wide, wr, req
   task automatic op1(input [3:0] o, input [15:0] d, input [2:0] r,
                      input [3:0] x);
      @(posedge clk);
      op <= o;
      op_data <= d;
      op_addr <= d;
      op_len <= r;
      op_reg <= r;
      op_pair <= r[1:0];
      op_bit <= r[0];
      {sdir_en, acc_wide, acc_wr, acc_req} <= x;
      @(posedge clk);
      op <= `CAS_OP_NONE;
      acc_req <= 1'b0;
      @(negedge clk);
   endtask
   task automatic irq_case(input r, input m, input n, input e);
      @(posedge clk);
      irq_req <= {17'h0, r};
      irq_mask <= {17'h0, m};
      nmi_req <= n;
      @(posedge clk);
      @(negedge clk);
      chk(irq_accept_q, e);
   endtask
   // =============================================
   // scenarios
   task automatic t_boot;
      for (int i = 0; i < 8 && boot_done_q !== 1'b1; i++)
         @(negedge clk);
      chk(ip_q, 16'h1234);
      chk(psb_q, 8'h02);
   endtask
   task automatic t_ip;
      op1(`CAS_OP_JUMP, 16'h2000, 3'h0, 4'h0);
      chk(ip_q, 16'h2000);
      op1(`CAS_OP_ADV, 16'h0000, 3'h3, 4'h0);
      chk(ip_q, 16'h2003);
   endtask
   task automatic t_stack;
      op1(`CAS_OP_LOAD_SP, 16'hfb10, 3'h0, 4'h0);
      op1(`CAS_OP_UNMASK, 16'h0000, 3'h0, 4'h0);
      chk(psb_q, 8'h82);
      op1(`CAS_OP_PUSH_PSB, 16'h0000, 3'h0, 4'h0);
      chk(sp_q, 16'hfb0f);
      chk(mem_wr_q, 1'b1);
      chk(mem_addr_q, 16'hfb0f);
      chk(mem_wdata_q, 8'h82);
      op1(`CAS_OP_MASK_ALL, 16'h0000, 3'h0, 4'h0);
      chk(psb_q, 8'h02);
      op1(`CAS_OP_POP_PSB, 16'h0000, 3'h0, 4'h0);
      @(negedge clk);
      chk(psb_q, 8'h82);
      chk(sp_q, 16'hfb10);
      repeat (2) @(posedge clk);
   endtask
   task automatic t_ack;
      op1(`CAS_OP_IRQ_ACK, 16'h0000, 3'h0, 4'h0);
      chk(sp_q, 16'hfb0f);
      chk(mem_wdata_q, 8'h82);
      chk(psb_q, 8'h02);
      op1(`CAS_OP_IRQ_RET, 16'h0000, 3'h0, 4'h0);
      @(negedge clk);
      chk(psb_q, 8'h82);
      chk(sp_q, 16'hfb10);
      repeat (2) @(posedge clk);
   endtask
   task automatic t_irq;
      irq_case(1'b1, 1'b0, 1'b0, 1'b1);
      irq_case(1'b1, 1'b1, 1'b0, 1'b0);
      irq_case(1'b1, 1'b1, 1'b1, 1'b1);
      op1(`CAS_OP_MASK_ALL, 16'h0000, 3'h0, 4'h0);
      irq_case(1'b1, 1'b0, 1'b0, 1'b0);
   endtask
   task automatic t_refuse;
      op1(`CAS_OP_LOAD_SP, 16'h1000, 3'h0, 4'h0);
      op1(`CAS_OP_PUSH_PSB, 16'h0000, 3'h0, 4'h0);
      chk(sp_q, 16'h1000);
      op1(`CAS_OP_UNMASK, 16'h0000, 3'h0, 4'h0);
      op1(`CAS_OP_IRQ_ACK, 16'h0000, 3'h0, 4'h0);
      chk(psb_q[7], 1'b0);
      chk(sp_q, 16'h1000);
   endtask
   task automatic t_flags;
      op1(`CAS_OP_WREG, 16'h000f, 3'h1, 4'h0);
      op1(`CAS_OP_ADD, 16'h0001, 3'h1, 4'h0);
      chk(psb_q & 8'h51, 8'h10);
      chk(regs_q[15:8], 8'h10);
      op1(`CAS_OP_ADD, 16'h00f0, 3'h1, 4'h0);
      chk(psb_q & 8'h51, 8'h41);
      op1(`CAS_OP_SUB, 16'h0001, 3'h1, 4'h0);
      chk(psb_q & 8'h51, 8'h11);
      op1(`CAS_OP_BITLD, 16'h0000, 3'h0, 4'h0);
      chk(psb_q[0], 1'b0);
      op1(`CAS_OP_WREG, 16'h0081, 3'h1, 4'h0);
      op1(`CAS_OP_ROT, 16'h0000, 3'h1, 4'h0);
      chk(regs_q[15:8], 8'h03);
      chk(psb_q & 8'h51, 8'h01);
   endtask
   task automatic t_pair;
      op1(`CAS_OP_WPAIR, 16'habcd, 3'h1, 4'h0);
      chk(regs_q[31:16], 16'habcd);
   endtask
   task automatic t_map;
      // expected: read strobe, region code, peripheral select
      logic [15:0] a [11] = '{16'h0023, 16'h0024, 16'h0040, 16'h007f,
         16'hf300, 16'hf6ff, 16'hfb00, 16'hfa4f, 16'hff00, 16'hffff,
         16'hfa50};
      logic [4:0] r [11] = '{5'h10, 5'h14, 5'h12, 5'h12, 5'h16, 5'h16,
         5'h16, 5'h18, 5'h1b, 5'h1b, 5'h1c};
      for (int i = 0; i < 11; i++) begin
         op1(`CAS_OP_NONE, a[i], 3'h0, 4'h1);
         chk({mem_rd_q, region_q, peri_sel_q}, r[i]);
      end
      op1(`CAS_OP_NONE, 16'h0010, 3'h0, 4'h9);
      chk(mem_addr_q, 16'hff10);
      op1(`CAS_OP_NONE, 16'h0030, 3'h0, 4'h9);
      chk(mem_addr_q, 16'hfe30);
      op1(`CAS_OP_NONE, 16'hff01, 3'h0, 4'h5);
      chk(peri_err_q, 1'b1);
      op1(`CAS_OP_NONE, 16'hff16, 3'h0, 4'h5);
      chk(peri_err_q, 1'b0);
   endtask
   // =============================================
   // sequence and hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         error_cnt++;
         tally_and_finish;
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_boot;
      t_ip;
      t_stack;
      t_ack;
      t_irq;
      t_refuse;
      t_flags;
      t_pair;
      t_map;
      tally_and_finish;
   end
endmodule // cas_core_state_tb_top
